/* File: hdl/mcu_bus_interface.sv */
// Parallel host port: strobe decode, address latch and data lanes
`timescale 1ns/1ps
module mcu_bus_interface (
   input wire logic ref_clk,                                // 40 MHz clock
   input wire logic rst_b,                                  // Sync reset, active low
   input wire host_port_pkg::cfg_t cfg_strap,               // Bus style straps
   input wire logic ctrl_in_0,                              // Write strobe or direction
   input wire logic ctrl_in_1,                              // Read strobe or data strobe
   input wire logic ctrl_in_2,                              // Fetch strobe, active low
   input wire logic address_strobe,                         // Address latch, active high
   input wire logic [host_port_pkg::SHARED_ADDR_DATA_PORT_W-1:0] shared_addr_data_port_in,    // Shared port level
   output logic [host_port_pkg::SHARED_ADDR_DATA_PORT_W-1:0] shared_addr_data_port_out,       // Shared port drive value
   output logic [host_port_pkg::SHARED_ADDR_DATA_PORT_W-1:0] shared_addr_data_port_oe,        // Shared port enable
   input wire logic [host_port_pkg::BYTE_W-1:0] port_a_in,  // Port A level
   input wire logic [host_port_pkg::BYTE_W-1:0] port_b_in,  // Port B level
   input wire logic [host_port_pkg::BYTE_W-1:0] port_c_in,  // Port C level
   input wire logic [host_port_pkg::BYTE_W-1:0] port_f_in,  // Port F level
   output logic [host_port_pkg::BYTE_W-1:0] port_f_out,     // Port F drive value
   output logic port_f_oe,                                  // Port F enable
   output logic [host_port_pkg::BYTE_W-1:0] port_e_out,     // Port E address out
   output logic port_e_oe,                                  // Port E enable
   output logic [host_port_pkg::BYTE_W-1:0] port_g_out,     // Port G address out
   output logic port_g_oe,                                  // Port G enable
   input wire logic host_sel,                               // Internal resource hit
   input wire logic [host_port_pkg::BYTE_W-1:0] rd_data,    // Internal read data
   output host_port_pkg::host_req_t req,                    // Access to internals
   output logic array_in,                                   // Spare fetch pin to array
   output logic ext_rd_n,                                   // Decoded read strobe
   output logic ext_wr_n                                    // Decoded write strobe
);
   import host_port_pkg::*;

   cfg_t cfg_reg;
   cfg_t cfg_next;
   host_req_t req_reg;
   host_req_t req_next;
   logic [SHARED_ADDR_DATA_PORT_W-1:0] shared_addr_data_port_out_reg, shared_addr_data_port_out_next, shared_addr_data_port_oe_reg, shared_addr_data_port_oe_next;
   logic [BYTE_W-1:0] pf_out_reg, pf_out_next, pe_out_reg, pe_out_next;
   logic [BYTE_W-1:0] pg_out_reg, pg_out_next;
   logic pf_oe_reg, pf_oe_next, pe_oe_reg, pe_oe_next, pg_oe_reg, pg_oe_next;
   logic arr_reg, arr_next, xrd_reg, xrd_next, xwr_reg, xwr_next;
   logic rd_s, wr_s, fetch_s, ds_s, drive;
   logic latch_en;
   logic [BYTE_W-1:0] lo_q, hi_q, ext_q, ext_live;

   // Only strobe while the bus is multiplexed; a stray strobe pin is ignored otherwise
   assign latch_en = cfg_reg.mux & address_strobe;

   addr_hold #(.W(BYTE_W)) u_lo (
      .ref_clk(ref_clk),
      .rst_b(rst_b),
      .load(latch_en),
      .d(shared_addr_data_port_in[LO_LSB +: BYTE_W]),
      .q(lo_q)
   );

   addr_hold #(.W(BYTE_W)) u_hi (
      .ref_clk(ref_clk),
      .rst_b(rst_b),
      .load(latch_en),
      .d(shared_addr_data_port_in[HI_LSB +: BYTE_W]),
      .q(hi_q)
   );

   addr_hold #(.W(BYTE_W)) u_ext (
      .ref_clk(ref_clk),
      .rst_b(rst_b),
      .load(latch_en),
      .d(ext_live),
      .q(ext_q)
   );

   // Extra address byte source; port F carries data on a non-multiplexed bus
   always_comb
   begin
      ext_live = BYTE_RST;
      unique case (cfg_reg.ext_src)
         EXT_A: ext_live = port_a_in;
         EXT_B: ext_live = port_b_in;
         EXT_C: ext_live = port_c_in;
         EXT_F: ext_live = cfg_reg.mux ? port_f_in : BYTE_RST;
         default: ext_live = BYTE_RST;
      endcase
      if (cfg_reg.a16_pa0)
         ext_live[A16_BIT-EXT_LSB] = port_a_in[0];
   end

   // Strobe decode
   always_comb
   begin
      ds_s = cfg_reg.ds_high ? ctrl_in_1 : ~ctrl_in_1;
      if (cfg_reg.rw_ds)
      begin
         rd_s = ds_s & ctrl_in_0;
         wr_s = ds_s & ~ctrl_in_0;
         fetch_s = 1'b0;
      end
      else
      begin
         wr_s = ~ctrl_in_0;
         rd_s = ~ctrl_in_1;
         fetch_s = ~cfg_reg.single_rd & ~ctrl_in_2;
      end
      drive = host_sel & (rd_s | fetch_s);
   end

   // Address, data lanes and port outputs
   always_comb
   begin
      cfg_next = rst_b ? cfg_reg : cfg_strap;
      req_next = REQ_RST;
      req_next.rd = rd_s;
      req_next.wr = wr_s;
      req_next.fetch = fetch_s;
      shared_addr_data_port_out_next = '0;
      shared_addr_data_port_oe_next = '0;
      pf_out_next = BYTE_RST;
      pf_oe_next = 1'b0;
      if (!cfg_reg.mux)
      begin
         // Address fully live, no strobe involved
         req_next.addr = {ext_live, shared_addr_data_port_in};
         req_next.wdata = port_f_in;
         pf_out_next = rd_data;
         pf_oe_next = drive;
      end
      else if (cfg_reg.burst)
      begin
         req_next.addr[BURST_TOP_LSB +: BURST_TOP_W] = ext_q[BURST_TOP_W-1:0];
         req_next.addr[BURST_HI_LSB +: BYTE_W] = hi_q;
         req_next.addr[BURST_LO_LSB +: BYTE_W] = lo_q;
         req_next.addr[LO_LSB +: NIB_W] = port_a_in[NIB_W-1:0];
         req_next.wdata = shared_addr_data_port_in[LO_LSB +: BYTE_W];
         shared_addr_data_port_out_next[LO_LSB +: BYTE_W] = rd_data;
         shared_addr_data_port_oe_next[LO_LSB +: BYTE_W] = {BYTE_W{drive}};
      end
      else if (cfg_reg.page)
      begin
         // Low byte is live so a page hit needs no new strobe
         req_next.addr = {ext_q, hi_q, shared_addr_data_port_in[LO_LSB +: BYTE_W]};
         req_next.wdata = shared_addr_data_port_in[HI_LSB +: BYTE_W];
         shared_addr_data_port_out_next[HI_LSB +: BYTE_W] = rd_data;
         shared_addr_data_port_oe_next[HI_LSB +: BYTE_W] = {BYTE_W{drive}};
      end
      else
      begin
         req_next.addr = {ext_q, hi_q, lo_q};
         req_next.wdata = shared_addr_data_port_in[LO_LSB +: BYTE_W];
         shared_addr_data_port_out_next[LO_LSB +: BYTE_W] = rd_data;
         shared_addr_data_port_oe_next[LO_LSB +: BYTE_W] = {BYTE_W{drive}};
      end
      if (cfg_reg.mux)
      begin
         pf_out_next = lo_q;
         pf_oe_next = cfg_reg.addr_out_f;
      end
      pe_out_next = lo_q;
      pe_oe_next = cfg_reg.mux & cfg_reg.addr_out_e;
      pg_out_next = cfg_reg.g_high ? hi_q : lo_q;
      pg_oe_next = cfg_reg.mux & cfg_reg.addr_out_g;
      // Fetch pin is free whenever no configuration uses it
      arr_next = (cfg_reg.rw_ds | cfg_reg.single_rd) & ctrl_in_2;
      xrd_next = ~(cfg_reg.rw_ds & rd_s);
      xwr_next = ~(cfg_reg.rw_ds & wr_s);
   end

   always_ff @(posedge ref_clk)
   begin
      cfg_reg <= cfg_next;
      if (!rst_b)
      begin
         req_reg <= REQ_RST;
         shared_addr_data_port_out_reg <= '0;
         shared_addr_data_port_oe_reg <= '0;
         pf_out_reg <= BYTE_RST;
         pf_oe_reg <= 1'b0;
         pe_out_reg <= BYTE_RST;
         pe_oe_reg <= 1'b0;
         pg_out_reg <= BYTE_RST;
         pg_oe_reg <= 1'b0;
         arr_reg <= 1'b0;
         xrd_reg <= 1'b1;
         xwr_reg <= 1'b1;
      end
      else
      begin
         req_reg <= req_next;
         shared_addr_data_port_out_reg <= shared_addr_data_port_out_next;
         shared_addr_data_port_oe_reg <= shared_addr_data_port_oe_next;
         pf_out_reg <= pf_out_next;
         pf_oe_reg <= pf_oe_next;
         pe_out_reg <= pe_out_next;
         pe_oe_reg <= pe_oe_next;
         pg_out_reg <= pg_out_next;
         pg_oe_reg <= pg_oe_next;
         arr_reg <= arr_next;
         xrd_reg <= xrd_next;
         xwr_reg <= xwr_next;
      end
   end

   assign req = req_reg;
   assign shared_addr_data_port_out = shared_addr_data_port_out_reg;
   assign shared_addr_data_port_oe = shared_addr_data_port_oe_reg;
   assign port_f_out = pf_out_reg;
   assign port_f_oe = pf_oe_reg;
   assign port_e_out = pe_out_reg;
   assign port_e_oe = pe_oe_reg;
   assign port_g_out = pg_out_reg;
   assign port_g_oe = pg_oe_reg;
   assign array_in = arr_reg;
   assign ext_rd_n = xrd_reg;
   assign ext_wr_n = xwr_reg;

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_b);

   a_cfg_frozen: assert property ($past(rst_b) |-> $stable(cfg_reg))
      else $error("configuration changed during operation");
   a_sep_write: assert property (!cfg_reg.rw_ds && !ctrl_in_0 |=> req.wr)
      else $error("write strobe not decoded");
   a_lo_latch: assert property (latch_en |=> lo_q == $past(shared_addr_data_port_in[7:0]))
      else $error("low address byte not latched");
   a_shared_addr_data_port_drive: assert property (|shared_addr_data_port_oe |-> $past(drive) && $past(cfg_reg.mux))
      else $error("shared port driven without selected read");
   a_port_e_addr: assert property (pe_oe_next |=> port_e_oe && port_e_out == $past(lo_q))
      else $error("port E does not show latched address");
   a_nonmux_addr: assert property (!cfg_reg.mux |=> req.addr[15:0] == $past(shared_addr_data_port_in))
      else $error("non-multiplexed address not taken live");
   a_port_f_hiz: assert property (!cfg_reg.mux && !drive |=> !port_f_oe)
      else $error("port F driven while not accessed");
   a_latch_hold: assert property (!latch_en |=> $stable(hi_q) && $stable(lo_q))
      else $error("address latch changed without strobe");
   a_single_read: assert property (!cfg_reg.rw_ds && cfg_reg.single_rd && !ctrl_in_1
      |=> req.rd && !req.fetch)
      else $error("single read strobe misdecoded");
   a_burst_nibble: assert property (cfg_reg.mux && cfg_reg.burst
      |=> req.addr[3:0] == $past(port_a_in[3:0]) && req.addr[11:4] == $past(lo_q))
      else $error("burst address lanes wrong");
   a_ext_strobes: assert property (cfg_reg.rw_ds && ds_s && ctrl_in_0
      |=> !ext_rd_n && ext_wr_n)
      else $error("decoded read strobe missing");
endmodule : mcu_bus_interface

/* File: hdl/host_port_pkg.sv */
// Shared types and constants for the parallel host port
package host_port_pkg;
   localparam int ADDR_W = 24;
   localparam int BYTE_W = 8;
   localparam int SHARED_ADDR_DATA_PORT_W = 16;
   localparam int NIB_W = 4;
   // Address field positions
   localparam int LO_LSB = 0;
   localparam int HI_LSB = 8;
   localparam int EXT_LSB = 16;
   localparam int BURST_LO_LSB = 4;
   localparam int BURST_HI_LSB = 12;
   localparam int BURST_TOP_LSB = 20;
   localparam int BURST_TOP_W = 4;
   localparam int A16_BIT = 16;
   // Reset values
   localparam logic [BYTE_W-1:0] BYTE_RST = 8'h00;
   localparam logic [ADDR_W-1:0] ADDR_RST = 24'h000000;

   typedef enum logic [2:0] {EXT_NONE, EXT_A, EXT_B, EXT_C, EXT_F} ext_src_t;

   // Bus style, fixed before operation
   typedef struct packed {
      logic mux;         // Multiplexed address/data bus
      logic rw_ds;       // Direction signal plus data strobe
      logic single_rd;   // Fetch strobe wired to ctrl_in_1
      logic page;        // Data shares the high address byte
      logic burst;       // Low nibble live on port A
      logic ds_high;     // Data strobe active high
      logic a16_pa0;     // A16 (A20 in burst mode) taken from port_a_bit0
      ext_src_t ext_src; // Source of address bits above 16 (A23-A20 only in burst mode)
      logic addr_out_e;  // Latched A7-A0 (A11-A4 in burst mode) on port E
      logic addr_out_f;  // Latched A7-A0 (A11-A4 in burst mode) on port F
      logic addr_out_g;  // Latched address on port G
      logic g_high;      // Port G carries A15-A8 (A19-A12 in burst mode)
   } cfg_t;

   // Access presented to internal memories and I/O
   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic rd;
      logic wr;
      logic fetch;
      logic [BYTE_W-1:0] wdata;
   } host_req_t;

   localparam host_req_t REQ_RST = '{ADDR_RST, 1'b0, 1'b0, 1'b0, BYTE_RST};
endpackage : host_port_pkg

/* File: hdl/addr_hold.sv */
// Loadable hold register for one latched address field
`timescale 1ns/1ps
module addr_hold #(
   parameter int W = 8
) (
   input wire logic ref_clk,        // System clock
   input wire logic rst_b,          // Synchronous reset, active low
   input wire logic load,           // Follow d while high
   input wire logic [W-1:0] d,      // Value to capture
   output logic [W-1:0] q           // Held value
);
   logic [W-1:0] q_reg;
   logic [W-1:0] q_next;

   always_comb
   begin
      q_next = load ? d : q_reg;
   end

   always_ff @(posedge ref_clk)
   begin
      if (!rst_b)
         q_reg <= '0;
      else
         q_reg <= q_next;
   end

   assign q = q_reg;
endmodule : addr_hold

/* File: sim/host_mcu_model.sv */
// Host processor bus model driving strobes and address/data lanes
`timescale 1ns/1ps
module host_mcu_model (
   input wire logic ref_clk, // System clock
   output logic [15:0] ad, // Address/data lane
   output logic ad_oe, // Host drives ad
   output logic [7:0] dat, // Port F data lane
   output logic dat_oe, // Host drives dat
   output logic [15:0] flt, // Level of a released line
   output logic [2:0] ctl, // Control inputs 2..0
   output logic as_hi // Address strobe
);
   logic flip = 1'b0;
   // No pull-ups: a released lane toggles so a stale value cannot pass
   assign flt = flip ? 16'ha55a : 16'h5aa5;
   always @(posedge ref_clk)
   begin
      flip <= ~flip;
   end
   // Called at a falling edge; holds the pins across exactly one rising edge
   task automatic step(input logic [15:0] a, input logic aoe, input logic s,
      input logic [2:0] c, input logic [7:0] d, input logic doe);
      {ad, ad_oe, as_hi, ctl, dat, dat_oe} = {a, aoe, s, c, d, doe};
      @(negedge ref_clk);
   endtask : step
endmodule : host_mcu_model

/* File: sim/mcu_bus_interface_tb.sv */
// Self-checking bench for the parallel host port
`timescale 1ns/1ps
module mcu_bus_interface_tb;
   import host_port_pkg::*;
   logic ref_clk = 1'b0;
   logic rst_b = 1'b0;
   cfg_t cfg_strap = '0;
   logic host_sel = 1'b1;
   logic [7:0] rd_data = 8'h3c;
   logic [7:0] pa = 8'h03;
   logic [7:0] pb = 8'h07;
   logic [7:0] pc = 8'h0b;
   logic [15:0] ad, flt, shared_addr_data_port_in, shared_addr_data_port_out, shared_addr_data_port_oe;
   logic [7:0] dat, pf_in, pf_out, pe_out, pg_out;
   logic [2:0] ctl;
   logic ad_oe, dat_oe, as_hi, pf_oe, pe_oe, pg_oe, array_in, ext_rd_n, ext_wr_n;
   host_req_t req;
   int err_count = 0;
   int cmp_count = 0;
   always #12.5 ref_clk = ~ref_clk;
   // Per bit the enabled driver wins; with nobody driving, the line wanders
   assign shared_addr_data_port_in = (shared_addr_data_port_oe & shared_addr_data_port_out) | (~shared_addr_data_port_oe & (ad_oe ? ad : flt));
   assign pf_in = pf_oe ? pf_out : (dat_oe ? dat : flt[15:8]);
   host_mcu_model i_host_mcu_model (.ref_clk(ref_clk), .ad(ad), .ad_oe(ad_oe), .dat(dat),
      .dat_oe(dat_oe), .flt(flt), .ctl(ctl), .as_hi(as_hi));
   mcu_bus_interface i_mcu_bus_interface (.ref_clk(ref_clk), .rst_b(rst_b),
      .cfg_strap(cfg_strap), .ctrl_in_0(ctl[0]), .ctrl_in_1(ctl[1]), .ctrl_in_2(ctl[2]),
      .address_strobe(as_hi), .shared_addr_data_port_in(shared_addr_data_port_in), .shared_addr_data_port_out(shared_addr_data_port_out), .shared_addr_data_port_oe(shared_addr_data_port_oe),
      .port_a_in(pa), .port_b_in(pb), .port_c_in(pc), .port_f_in(pf_in),
      .port_f_out(pf_out), .port_f_oe(pf_oe), .port_e_out(pe_out), .port_e_oe(pe_oe),
      .port_g_out(pg_out), .port_g_oe(pg_oe), .host_sel(host_sel), .rd_data(rd_data),
      .req(req), .array_in(array_in), .ext_rd_n(ext_rd_n), .ext_wr_n(ext_wr_n));
   task automatic chk(input string nm, input logic [47:0] ev, input logic [47:0] got);
      cmp_count++;
      if (got !== ev)
      begin
         err_count++;
         $display("CHECK FAILED %s expected %h seen %h", nm, ev, got);
      end
   endtask : chk
   task automatic tally_and_finish;
      $display("comparisons %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : tally_and_finish
   task automatic st(input logic [15:0] a, input logic aoe, input logic s,
      input logic [2:0] c, input logic [7:0] d, input logic doe);
      i_host_mcu_model.step(a, aoe, s, c, d, doe);
   endtask : st
   task automatic do_reset(input cfg_t c);
      cfg_strap = c;
      rst_b = 1'b0;
      st(16'h0000, 0, 0, 3'b111, 8'h00, 0);
      repeat (15) @(negedge ref_clk);
      rst_b = 1'b1;
   endtask : do_reset
   task automatic t_mux;
      do_reset(cfg_t'({7'b1000000, EXT_A, 4'b1111}));
      st(16'h12a5, 1, 1, 3'b111, 8'h00, 0);
      st(16'h0000, 0, 0, 3'b101, 8'h00, 0);
      chk("rd", 1, req.rd);
      chk("addr", 24'h0312a5, req.addr);
      chk("rd lane", {16'h00ff, 8'h3c}, {shared_addr_data_port_oe, shared_addr_data_port_out[7:0]});
      chk("port e", {1'b1, 8'ha5}, {pe_oe, pe_out});
      chk("port g", {1'b1, 8'h12}, {pg_oe, pg_out});
      chk("port f", {1'b1, 8'ha5}, {pf_oe, pf_out});
      st(16'h0000, 0, 0, 3'b111, 8'h00, 0);
      chk("oe idle", 16'h0000, shared_addr_data_port_oe);
      host_sel = 1'b0;
      st(16'h0000, 0, 0, 3'b101, 8'h00, 0);
      chk("oe unsel", 16'h0000, shared_addr_data_port_oe);
      host_sel = 1'b1;
      st(16'h0077, 1, 0, 3'b110, 8'h00, 0);
      chk("wr", {2'b01, 8'h77, 16'h0000}, {req.rd, req.wr, req.wdata, shared_addr_data_port_oe});
      st(16'h0000, 0, 0, 3'b011, 8'h00, 0);
      chk("fetch", {1'b1, 16'h00ff}, {req.fetch, shared_addr_data_port_oe});
      // Registered enable drops one edge after the strobe; host waits before its address
      st(16'h0000, 0, 0, 3'b111, 8'h00, 0);
      chk("oe fetch end", 16'h0000, shared_addr_data_port_oe);
      // Straps move after reset; the bus style must not follow them
      cfg_strap = '0;
      st(16'h4321, 1, 1, 3'b111, 8'h00, 0);
      st(16'h0000, 0, 0, 3'b101, 8'h00, 0);
      chk("frozen", 24'h034321, req.addr);
   endtask : t_mux
   task automatic t_ext;
      ext_src_t srcs[4] = '{EXT_A, EXT_B, EXT_C, EXT_F};
      logic [7:0] ev;
      for (int m = 0; m < 2; m++)
      begin
         for (int i = 0; i < 4; i++)
         begin
            do_reset(cfg_t'({m[0], 6'b000000, srcs[i], 4'b0000}));
            st(16'hbeef, 1, m[0], 3'b111, 8'h0f, 1);
            st(16'hbeef, !m[0], 0, 3'b101, 8'h0f, m[0]);
            ev = (i == 3) ? (m[0] ? 8'h0f : 8'h00) : (i == 0 ? pa : (i == 1 ? pb : pc));
            chk("ext addr", {ev, 16'hbeef}, req.addr);
         end
      end
   endtask : t_ext
   task automatic t_nonmux;
      do_reset(cfg_t'({7'b0, EXT_NONE, 4'b0}));
      st(16'hbeef, 1, 0, 3'b111, 8'h00, 0);
      chk("f idle", 0, pf_oe);
      rd_data = 8'hc3;
      st(16'hbeef, 1, 0, 3'b101, 8'h00, 0);
      chk("nm rd", {2'b11, 8'hc3, 16'h0000}, {req.rd, pf_oe, pf_out, shared_addr_data_port_oe});
      // Port F must be released before the host drives write data on it
      st(16'hbef0, 1, 0, 3'b111, 8'h00, 0);
      chk("f released", 0, pf_oe);
      st(16'hbef0, 1, 0, 3'b110, 8'h5e, 1);
      chk("nm wr", {2'b10, 8'h5e, 24'h00bef0}, {req.wr, pf_oe, req.wdata, req.addr});
   endtask : t_nonmux
   task automatic t_page;
      do_reset(cfg_t'({7'b1001000, EXT_NONE, 4'b0010}));
      rd_data = 8'h9a;
      st(16'h5612, 1, 1, 3'b111, 8'h00, 0);
      for (int k = 0; k < 2; k++)
      begin
         st({8'h00, 8'h34 + k[7:0]}, 1, 0, 3'b101, 8'h00, 0);
         chk("pg addr", 24'h005634 + k, req.addr);
         chk("pg data", {16'hff00, 8'h9a}, {shared_addr_data_port_oe, shared_addr_data_port_out[15:8]});
      end
      chk("pg ports", {3'b001, 8'h12}, {pe_oe, pf_oe, pg_oe, pg_out});
   endtask : t_page
   task automatic t_burst;
      do_reset(cfg_t'({7'b1000100, EXT_NONE, 4'b0}));
      st(16'habcd, 1, 1, 3'b111, 8'h00, 0);
      for (int k = 0; k < 16; k++)
      begin
         pa = k[7:0];
         rd_data = 8'h40 + k[7:0];
         st(16'h0000, 0, 0, 3'b011, 8'h00, 0);
         chk("bu addr", {20'h0abcd, k[3:0]}, req.addr);
         chk("bu data", {8'hff, 8'h40 + k[7:0]}, {shared_addr_data_port_oe[7:0], shared_addr_data_port_out[7:0]});
      end
   endtask : t_burst
   task automatic t_single;
      do_reset(cfg_t'({7'b1010001, EXT_NONE, 4'b0}));
      pa = 8'h01;
      st(16'h2222, 1, 1, 3'b111, 8'h00, 0);
      st(16'h0000, 0, 0, 3'b001, 8'h00, 0);
      chk("single", {4'b1000, 24'h012222}, {req.rd, req.fetch, array_in, req.wr, req.addr});
      st(16'h0000, 0, 0, 3'b111, 8'h00, 0);
      chk("spare", 1, array_in);
   endtask : t_single
   task automatic t_rwds;
      logic [4:0] ev;
      for (int p = 0; p < 2; p++)
      begin
         do_reset(cfg_t'({5'b11000, p[0], 1'b0, EXT_NONE, 4'b0}));
         for (int k = 0; k < 4; k++)
         begin
            // Data strobe level follows the strapped polarity
            st(16'h0000, 0, 0, {k[1], k[1] ~^ p[0], k[0]}, 8'h00, 0);
            ev = {~(k[1] & k[0]), ~(k[1] & ~k[0]), k[1], k[1] & k[0], k[1] & ~k[0]};
            chk("rw ds", ev, {ext_rd_n, ext_wr_n, array_in, req.rd, req.wr});
         end
      end
   endtask : t_rwds
   initial
   begin
      do_reset('0);
      chk("rst req", REQ_RST, req);
      chk("rst pins", {2'b11, 16'h0000, 1'b0}, {ext_rd_n, ext_wr_n, shared_addr_data_port_oe, pf_oe});
      t_mux();
      t_ext();
      t_nonmux();
      t_page();
      t_burst();
      t_single();
      t_rwds();
      tally_and_finish();
   end
   // The full run needs about 300 cycles; allow several times that
   initial
   begin
      #50000;
      err_count++;
      tally_and_finish();
   end
endmodule : mcu_bus_interface_tb
